// [design/sas_adc_seq.sv]
// Purpose: apb-controlled sequencer for a 10-bit sar converter, 8 inputs
// Assumes: analog mux, sample switch, tap dac and comparator sit outside
// Notes:   comparator tap sits half an lsb below trial_code
// Operation
// - with the run bit set, conversions repeat back to back until cleared
// - channel write aborts the conversion; restarts from step one if running
// - reset clears the wide result and the byte result to zero
// - wide result holds the code shifted left six places
// - byte result updates together with the wide result
// - final code rounds input ratio times 1024 to nearest
// - single selected channel out of eight, from channel bits 2..0
// - at the end: latch result, raise completion, start next at once
// - clearing the run bit halts at once; results keep last value
// - after a channel change, completion comes one conversion time and one cycle later
// - conversion time covers sampling plus all bit trials
// - ten comparisons msb to lsb, result transferred after the last
// - a result read coinciding with the update completes first
// - config write at completion wins; no result update, no completion
`timescale 1ns/1ns
module sas_adc_seq #(
	parameter int STEP_BASE    = sas_pkg::STEP_BASE_CYC,
	parameter int SAMPLE_TICKS = sas_pkg::SAMPLE_TICKS
) (
	// clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [sas_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	// analog front end
	output logic                               comparator_enable_bit,
	output logic [sas_pkg::CHAN_W-1:0]         analog_chan,
	output logic                               sample_hold,
	output logic [sas_pkg::CODE_W-1:0]         tap_code,
	input  wire logic                          comp_above,
	output logic [sas_pkg::PINCFG_W-1:0]       analog_pin_config,
	// completion event
	output logic                               conversion_done_irq
);
	// divider width covers the longest step, thirty-two times STEP_BASE
	localparam int DIV_W = $clog2(32 * STEP_BASE + 1);

	// refuse settings the step divider and engine cannot serve
	if (STEP_BASE < 1 || SAMPLE_TICKS < 1 || SAMPLE_TICKS > 8)
		$error("sas_adc_seq: STEP_BASE or SAMPLE_TICKS out of range");

	// the justified result and its byte form must fit the shared widths
	if (sas_pkg::CODE_W + sas_pkg::JUSTIFY_SHIFT != sas_pkg::WIDE_W
		|| sas_pkg::BYTE_W > sas_pkg::CODE_W)
		$error("sas_adc_seq: result field widths do not agree");

	// register map, one aligned word each, data in the low bits:
	//   mode      comparator enable, conversion time field, run bit
	//   channel   three bits naming one of eight inputs
	//   pins      analog or digital use of the input pins
	//   wide      result code justified to the top of sixteen bits
	//   byte      upper eight bits of the result code
	//   status    busy, comparator settled, result pending
	// upper bits read as zero; writes to the read-only words are
	// refused with an error response and leave every register alone
	// unmapped words read zero and also answer with an error
	// offsets live in the shared package and may be moved there alone
	// the status word is read-only and reading it has no side effects
	// the mode word may be rewritten while running; see run control

	// register state, all cleared by reset
	logic [sas_pkg::MODE_W-1:0]    converter_mode_reg_r;
	logic [sas_pkg::CHAN_W-1:0]    channel_select_reg_r;
	logic [sas_pkg::PINCFG_W-1:0]  analog_pin_config_reg_r;
	logic [sas_pkg::WIDE_W-1:0]    conversion_result_wide_r;
	logic [sas_pkg::BYTE_W-1:0]    conversion_result_byte_r;
	logic [31:0]                   prdata_r;
	logic                          irq_r;
	logic                          pend_r;
	logic [sas_pkg::CODE_W-1:0]    pend_code_r;
	logic [DIV_W-1:0]              div_r;
	logic [8:0]                    settle_r;

	// decoded bus activity
	// everything here is combinational from the bus inputs and registers
	logic                          setup_rd;
	logic                          wr_now;
	logic                          wr_mode;
	logic                          wr_chan;
	logic                          wr_pin;
	logic                          cfg_wr;
	logic                          res_rd;
	logic                          mapped;
	logic                          writable;
	logic                          run_r;
	logic                          run_go;
	logic                          restart;
	logic                          tick;
	logic [DIV_W-1:0]              period_m1;
	logic [31:0]                   rd_mux;
	logic                          res_wr;
	logic [sas_pkg::CODE_W-1:0]    res_code;

	// engine side
	// activity flag and finished code of the approximation engine
	logic                          busy;
	logic                          eng_done;
	logic [sas_pkg::CODE_W-1:0]    eng_code;

	// address match against one register offset
	function automatic logic hit(input logic [sas_pkg::ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a[sas_pkg::ADDR_W-1:2] == off[sas_pkg::ADDR_W-1:2]);
	endfunction : hit

	// bus decode: a write lands at the access edge; a read is set up
	// one cycle earlier so its data can come from a flip-flop
	// offsets match on the word index, byte lanes are ignored
	assign wr_now   = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign wr_mode  = wr_now && hit(paddr, sas_pkg::OFF_MODE);
	assign wr_chan  = wr_now && hit(paddr, sas_pkg::OFF_CHAN);
	assign wr_pin   = wr_now && hit(paddr, sas_pkg::OFF_PINCFG);
	assign cfg_wr   = wr_mode || wr_chan || wr_pin;
	assign res_rd   = psel && !pwrite && (hit(paddr, sas_pkg::OFF_RES_WIDE)
		|| hit(paddr, sas_pkg::OFF_RES_BYTE));
	assign writable = hit(paddr, sas_pkg::OFF_MODE) || hit(paddr, sas_pkg::OFF_CHAN)
		|| hit(paddr, sas_pkg::OFF_PINCFG);
	assign mapped   = writable || hit(paddr, sas_pkg::OFF_RES_WIDE)
		|| hit(paddr, sas_pkg::OFF_RES_BYTE) || hit(paddr, sas_pkg::OFF_STATUS);

	// zero wait states; error on unmapped or read-only write
	// ready is tied high, so every access phase lasts one cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && !writable));
	assign prdata  = prdata_r;

	// run control: start and halt both act at the edge of the mode write;
	// the engine sees the value being written, not the stored bit, so a
	// start is not lost behind the old run bit and a halt drops the next step
	// a channel write while running, or a fresh start, restarts from sampling
	assign run_r   = converter_mode_reg_r[sas_pkg::MODE_RUN_BIT];
	assign run_go  = wr_mode ? pwdata[sas_pkg::MODE_RUN_BIT] : run_r;
	assign restart = (wr_chan && run_r)
		|| (wr_mode && pwdata[sas_pkg::MODE_RUN_BIT] && !run_r);

	// mode register: comparator enable, conversion time, run bit
	// the whole byte is stored; unused bit 6 reads back as written
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			converter_mode_reg_r <= sas_pkg::MODE_RST;
		else if (wr_mode)
			converter_mode_reg_r <= pwdata[sas_pkg::MODE_W-1:0];
	end

	// channel select, three bits of a single channel
	// a write here also restarts a running conversion, see run control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			channel_select_reg_r <= sas_pkg::CHAN_RST;
		else if (wr_chan)
			channel_select_reg_r <= pwdata[sas_pkg::CHAN_W-1:0];
	end

	// pin configuration, passed straight to the port logic
	// no effect on conversion timing; the port logic decides pin use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			analog_pin_config_reg_r <= sas_pkg::PINCFG_RST;
		else if (wr_pin)
			analog_pin_config_reg_r <= pwdata[sas_pkg::PINCFG_W-1:0];
	end

	// step divider; period scales with the conversion time field
	// one step lasts (time field + 1) * STEP_BASE cycles; a conversion is
	// SAMPLE_TICKS sampling steps plus ten trial steps, so the whole time
	// from the restart edge to the last trial is a fixed number of steps
	// the count restarts with the engine, so after a channel write the next
	// completion is exactly one conversion time plus one cycle away
	// changing the time field while running sets the length of the current step and every later one
	// tick is a single-cycle enable; nothing here runs on a second clock
	// the divider holds at zero while the engine is idle
	assign period_m1 = DIV_W'((32'(converter_mode_reg_r[sas_pkg::MODE_TIME_LSB +:
		sas_pkg::MODE_TIME_W]) + 32'd1) * 32'(STEP_BASE) - 32'd1);
	assign tick = (div_r >= period_m1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_r <= '0;
		else if (restart || !busy || tick)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// comparator settling counter, visible as a status bit
	// software must still wait for it; the run bit is not held back here
	// the count saturates and clears as soon as the comparator is disabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			settle_r <= '0;
		else if (!converter_mode_reg_r[sas_pkg::MODE_CMP_BIT])
			settle_r <= '0;
		else if (settle_r != 9'(sas_pkg::SETTLE_CYC))
			settle_r <= settle_r + 1'b1;
	end

	// walk of one conversion, N cycles a step, S sampling steps:
	//   edge E             restart; sampling begins, step count cleared
	//   E+N .. E+S*N       sampling steps, the input follows the switch
	//   E+(S+1)*N ..       ten trials, msb first, last one at E+(S+10)*N
	//   one edge later     both result words written, unless held or dropped
	//   same edge          completion pulse high for a single cycle
	//   last trial edge    the next conversion already starts sampling

	// conversion engine
	// the tap code goes to the resistor string, the comparator answers on
	// comp_above, and the engine decides one bit per step from the top down
	sas_sar_core #(
		.CODE_W       (sas_pkg::CODE_W),
		.SAMPLE_TICKS (SAMPLE_TICKS)
	) u_core (
		.pclk       (pclk),
		.presetn    (presetn),
		.run        (run_go),
		.restart    (restart),
		.tick       (tick),
		.comp_above (comp_above),
		.busy       (busy),
		.sampling   (sample_hold),
		.trial_code (tap_code),
		.done       (eng_done),
		.code       (eng_code)
	);

	// result write: config write drops it, a result read defers it
	// a config write in the cycle the engine finishes wins outright: no
	// result update and no completion pulse for that conversion
	// a read of either result word, from setup to access, holds the update
	// back so the reader sees the old pair; the new code waits in pend
	// and lands in the first cycle after the read, with its pulse
	assign res_wr   = !res_rd && ((eng_done && !cfg_wr) || pend_r);
	assign res_code = pend_r ? pend_code_r : eng_code;

	// deferred result held while a read of the results is in flight
	// only one code is kept: a read lasts two cycles, a conversion far longer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_r      <= 1'b0;
			pend_code_r <= '0;
		end
		else if (eng_done && !cfg_wr && res_rd)
		begin
			pend_r      <= 1'b1;
			pend_code_r <= eng_code;
		end
		else if (res_wr || cfg_wr)
			pend_r <= 1'b0;
	end

	// result registers, left justified wide form and upper byte
	// both words change on the same edge, so a reader never sees a wide
	// word and a byte word from different conversions
	// clearing the run bit leaves both holding the last completed code
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conversion_result_wide_r <= sas_pkg::RES_WIDE_RST;
			conversion_result_byte_r <= sas_pkg::RES_BYTE_RST;
		end
		else if (res_wr)
		begin
			conversion_result_wide_r <= {res_code, {sas_pkg::JUSTIFY_SHIFT{1'b0}}};
			conversion_result_byte_r <= res_code[sas_pkg::CODE_W-1 -:
				sas_pkg::BYTE_W];
		end
	end

	// completion pulse, raised with the result update only
	// it rises on the result edge and lasts one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_r <= 1'b0;
		else
			irq_r <= res_wr;
	end

	// read mux
	// unmapped words and unused upper bits read back as zero
	// status shows engine activity, settled comparator and a deferred result
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (hit(paddr, sas_pkg::OFF_MODE))
			rd_mux[sas_pkg::MODE_W-1:0] = converter_mode_reg_r;
		else if (hit(paddr, sas_pkg::OFF_CHAN))
			rd_mux[sas_pkg::CHAN_W-1:0] = channel_select_reg_r;
		else if (hit(paddr, sas_pkg::OFF_PINCFG))
			rd_mux[sas_pkg::PINCFG_W-1:0] = analog_pin_config_reg_r;
		else if (hit(paddr, sas_pkg::OFF_RES_WIDE))
			rd_mux[sas_pkg::WIDE_W-1:0] = conversion_result_wide_r;
		else if (hit(paddr, sas_pkg::OFF_RES_BYTE))
			rd_mux[sas_pkg::BYTE_W-1:0] = conversion_result_byte_r;
		else if (hit(paddr, sas_pkg::OFF_STATUS))
		begin
			rd_mux[sas_pkg::STAT_BUSY_BIT]    = busy;
			rd_mux[sas_pkg::STAT_SETTLED_BIT] = (settle_r == 9'(sas_pkg::SETTLE_CYC));
			rd_mux[sas_pkg::STAT_PEND_BIT]    = pend_r;
		end
	end

	// read data captured in the setup cycle, shown in the access cycle
	// sampled early so that a result update deferred by the same read
	// cannot change what the reader gets; held until the next read setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (setup_rd)
			prdata_r <= rd_mux;
	end

	// front-end outputs
	// all come straight from registers, so the analog side sees no glitches
	// pin configuration is passed on for the port muxes outside
	assign comparator_enable_bit = converter_mode_reg_r[sas_pkg::MODE_CMP_BIT];
	assign analog_chan           = channel_select_reg_r;
	assign analog_pin_config     = analog_pin_config_reg_r;
	assign conversion_done_irq   = irq_r;
endmodule : sas_adc_seq

// [pkg/sas_pkg.sv]
// Purpose: shared constants and types of the sar converter sequencer
// Assumes: apb register map, 32-bit data, one word per register
// Notes:   every offset, field, reset value and timing count lives here
package sas_pkg;
	// register byte offsets
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFF_MODE     = 8'h00;
	localparam logic [7:0]  OFF_CHAN     = 8'h04;
	localparam logic [7:0]  OFF_PINCFG   = 8'h08;
	localparam logic [7:0]  OFF_RES_WIDE = 8'h0C;
	localparam logic [7:0]  OFF_RES_BYTE = 8'h10;
	localparam logic [7:0]  OFF_STATUS   = 8'h14;
	// field layout
	localparam int          MODE_W       = 8;
	localparam int          MODE_CMP_BIT = 0;
	localparam int          MODE_TIME_LSB = 1;
	localparam int          MODE_TIME_W  = 5;
	localparam int          MODE_RUN_BIT = 7;
	localparam int          CHAN_W       = 3;
	localparam int          PINCFG_W     = 4;
	localparam int          CODE_W       = 10;
	localparam int          WIDE_W       = 16;
	localparam int          BYTE_W       = 8;
	localparam int          JUSTIFY_SHIFT = 6;
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_SETTLED_BIT = 1;
	localparam int          STAT_PEND_BIT = 2;
	// reset values
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [2:0]  CHAN_RST     = 3'h0;
	localparam logic [3:0]  PINCFG_RST   = 4'h0;
	localparam logic [15:0] RES_WIDE_RST = 16'h0000;
	localparam logic [7:0]  RES_BYTE_RST = 8'h00;
	// timing
	localparam int          SAMPLE_TICKS = 2;
	localparam int          STEP_BASE_CYC = 4;
	localparam int          CLK_NS       = 4;
	localparam int          SETTLE_NS    = 1000;
	localparam int          SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// conversion engine states
	typedef enum logic [2:0]
	{
		SAS_IDLE    = 3'b001,
		SAS_SAMPLE  = 3'b010,
		SAS_COMPARE = 3'b100
	} sas_state_t;
endpackage : sas_pkg

// [design/sas_sar_core.sv]
// Purpose: successive-approximation engine, sample phase then bit trials
// Assumes: tick is a one-cycle step enable; comp_above is valid at tick
// Notes:   trial_code is the tap code the analog side compares against
`timescale 1ns/1ns
module sas_sar_core #(
	parameter int CODE_W       = sas_pkg::CODE_W,
	parameter int SAMPLE_TICKS = sas_pkg::SAMPLE_TICKS
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// control
	input  wire logic              run,
	input  wire logic              restart,
	input  wire logic              tick,
	input  wire logic              comp_above,
	// status and result
	output logic                   busy,
	output logic                   sampling,
	output logic [CODE_W-1:0]      trial_code,
	output logic                   done,
	output logic [CODE_W-1:0]      code
);
	localparam int CNT_W = $clog2(CODE_W + SAMPLE_TICKS + 1);

	sas_pkg::sas_state_t   state_r;
	logic [CNT_W-1:0]      cnt_r;
	logic [CODE_W-1:0]     sar_r;
	logic [CODE_W-1:0]     sar_cmp;
	logic                  fin;

	// current trial bit replaced by the comparator decision
	always_comb
	begin
		sar_cmp = sar_r;
		for (int i = 0; i < CODE_W; i++)
			if (cnt_r == CNT_W'(i))
				sar_cmp[i] = comp_above;
	end

	assign fin = run && !restart && tick && (state_r == sas_pkg::SAS_COMPARE)
		&& (cnt_r == '0);

	// sequencing: sample ticks, then one trial per tick from msb down
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= sas_pkg::SAS_IDLE;
			cnt_r   <= '0;
			sar_r   <= '0;
		end
		else if (!run)
			state_r <= sas_pkg::SAS_IDLE;
		else if (restart)
		begin
			state_r <= sas_pkg::SAS_SAMPLE;
			cnt_r   <= '0;
		end
		else if (tick)
		begin
			unique case (state_r)
				sas_pkg::SAS_IDLE:
					state_r <= sas_pkg::SAS_IDLE;
				sas_pkg::SAS_SAMPLE:
					if (cnt_r == CNT_W'(SAMPLE_TICKS - 1))
					begin
						state_r <= sas_pkg::SAS_COMPARE;
						cnt_r   <= CNT_W'(CODE_W - 1);
						sar_r   <= {1'b1, {(CODE_W-1){1'b0}}};
					end
					else
						cnt_r <= cnt_r + 1'b1;
				sas_pkg::SAS_COMPARE:
					if (cnt_r == '0)
					begin
						state_r <= sas_pkg::SAS_SAMPLE;
						cnt_r   <= '0;
					end
					else
					begin
						sar_r <= sar_cmp | (CODE_W'(1) << (cnt_r - 1'b1));
						cnt_r <= cnt_r - 1'b1;
					end
			endcase
		end
	end

	// finished code and its one-cycle completion pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done <= 1'b0;
			code <= '0;
		end
		else
		begin
			done <= fin;
			if (fin)
				code <= sar_cmp;
		end
	end

	assign busy       = (state_r != sas_pkg::SAS_IDLE);
	assign sampling   = (state_r == sas_pkg::SAS_SAMPLE);
	assign trial_code = sar_r;
endmodule : sas_sar_core

// [tb/sas_adc_seq_asserts.sv]
// Purpose: port-level checks of the converter sequencer
// Assumes: zero-wait apb slave, single clock domain
// Notes:   run state and conversion length are rebuilt from apb writes
`timescale 1ns/1ns
module sas_adc_seq_asserts #(
	parameter int STEP_BASE    = 4,
	parameter int SAMPLE_TICKS = 2
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// converter side
	input wire logic        comparator_enable_bit,
	input wire logic [2:0]  analog_chan,
	input wire logic        sample_hold,
	input wire logic        conversion_done_irq
);
	logic        run_r;
	logic [4:0]  tsel_r;
	logic [3:0]  idle_r;
	logic [15:0] gap_r;
	logic        clean_r;
	logic [15:0] conv_w;
	logic        wr_w;
	logic        wmode_w;
	// write strobes and expected conversion length
	assign wr_w = psel & penable & pwrite & pready;
	assign wmode_w = wr_w && paddr == sas_pkg::OFF_MODE;
	assign conv_w = 16'((int'(tsel_r) + 1) * STEP_BASE * (SAMPLE_TICKS + 10));
	// track run bit, idle time and quiet gaps between completions
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			run_r <= 1'b0;
			tsel_r <= 5'h00;
			idle_r <= 4'h0;
			gap_r <= 16'h0000;
			clean_r <= 1'b0;
		end
		else
		begin
			if (wmode_w)
			begin
				run_r <= pwdata[7];
				tsel_r <= pwdata[5:1];
				idle_r <= 4'h0;
			end
			else if (!run_r && idle_r != 4'hF)
				idle_r <= idle_r + 4'h1;
			gap_r <= conversion_done_irq ? 16'h0000 : gap_r + 16'h0001;
			clean_r <= psel ? 1'b0 : (conversion_done_irq ? 1'b1 : clean_r);
		end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	unmapped_err_a: assert property (psel && penable && paddr > (sas_pkg::OFF_STATUS | 8'h03)
		|-> pslverr)
		else $error("unmapped access without error");
	ro_write_err_a: assert property (wr_w && (paddr == sas_pkg::OFF_RES_WIDE
		|| paddr == sas_pkg::OFF_RES_BYTE) |-> pslverr)
		else $error("result write without error");
	irq_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("completion longer than one cycle");
	stop_quiet_a: assert property (!run_r && idle_r >= 4'h2 |-> !conversion_done_irq)
		else $error("completion while stopped");
	stop_sample_a: assert property (!run_r && idle_r >= 4'h2 |-> !sample_hold)
		else $error("sampling while stopped");
	conv_gap_a: assert property (conversion_done_irq && clean_r |-> gap_r == conv_w - 16'h0001)
		else $error("completion spacing wrong");
	chan_restart_a: assert property (wr_w && paddr == sas_pkg::OFF_CHAN && run_r
		|=> !conversion_done_irq [*8])
		else $error("completion too soon after channel write");
	chan_out_a: assert property (wr_w && paddr == sas_pkg::OFF_CHAN
		|=> analog_chan == $past(pwdata[2:0]))
		else $error("channel not applied");
	cmp_en_a: assert property (wmode_w |=> comparator_enable_bit == $past(pwdata[0]))
		else $error("comparator enable not applied");
	wide_fmt_a: assert property (psel && penable && !pwrite && paddr == sas_pkg::OFF_RES_WIDE
		|-> prdata[31:16] == 16'h0000 && prdata[5:0] == 6'h00)
		else $error("wide result not left justified");
endmodule : sas_adc_seq_asserts

bind sas_adc_seq sas_adc_seq_asserts #(.STEP_BASE(STEP_BASE), .SAMPLE_TICKS(SAMPLE_TICKS)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.comparator_enable_bit, .analog_chan, .sample_hold, .conversion_done_irq);

// [tb/tb_sar_adc_sequencer.sv]
// Purpose: self-checking bench of the converter sequencer
// Assumes: comparator modelled from per-channel inputs in half-lsb units
// Notes:   step base 1 and time field 0 keep a conversion at 12 cycles
`timescale 1ns/1ns
module tb_sar_adc_sequencer;
	localparam int SB   = 1;
	localparam int CONV = 12 * SB;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, cmp_en, shold, irq, err, got;
	logic [2:0]  chan;
	logic [9:0]  tap, e;
	logic [3:0]  pcfg;
	logic [10:0] vin [8];
	logic [10:0] v;
	logic        comp_above;
	int          n_fail = 0, check_count = 0, cyc = 0, seed = 31845;
	int          t_wr, t_got, t1, d_start;
	// comparator trips half an lsb below the tap
	assign comp_above = {1'b0, vin[chan]} + 12'h001 >= {1'b0, tap, 1'b0};
	always #2 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	sas_adc_seq #(.STEP_BASE(SB), .SAMPLE_TICKS(2)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.comparator_enable_bit(cmp_en), .analog_chan(chan), .sample_hold(shold),
		.tap_code(tap), .comp_above(comp_above), .analog_pin_config(pcfg),
		.conversion_done_irq(irq));
	// expected code, rounded to nearest
	function automatic logic [9:0] code_of(input logic [10:0] hv);
		logic [11:0] s;
		s = {1'b0, hv} + 12'h001;
		return s[10:1];
	endfunction : code_of
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		t_wr = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000);
		check(n, rd, x);
	endtask : rdchk
	task automatic wait_irq(input int lim);
		got = 1'b0;
		repeat (lim)
		begin
			@(posedge pclk);
			if (irq === 1'b1)
			begin
				got = 1'b1;
				t_got = cyc;
				break;
			end
		end
	endtask : wait_irq
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	// watchdog
	initial
	begin
		repeat (8000) @(posedge pclk);
		n_fail++;
		test_done();
	end
	// main sequence
	initial
	begin
		for (int i = 0; i < 8; i++)
			vin[i] = 11'h000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("wide reset", sas_pkg::OFF_RES_WIDE, 32'h00000000);
		rdchk("byte reset", sas_pkg::OFF_RES_BYTE, 32'h00000000);
		apb(1'b1, sas_pkg::OFF_RES_BYTE, 32'h000000FF);
		check("ro write error", 32'(err), 32'h00000001);
		rdchk("unmapped read", 8'h40, 32'h00000000);
		check("unmapped error", 32'(err), 32'h00000001);
		$display("test reset and map done");
		apb(1'b1, sas_pkg::OFF_MODE, 32'h00000001);
		repeat (sas_pkg::SETTLE_CYC) @(posedge pclk);
		rdchk("status settled", sas_pkg::OFF_STATUS, 32'(1) << sas_pkg::STAT_SETTLED_BIT);
		apb(1'b1, sas_pkg::OFF_PINCFG, 32'h00000008);
		rdchk("pin config read", sas_pkg::OFF_PINCFG, 32'h00000008);
		check("pin config out", 32'(pcfg), 32'h00000008);
		apb(1'b1, sas_pkg::OFF_PINCFG, 32'h00000000);
		apb(1'b1, sas_pkg::OFF_CHAN, 32'h00000000);
		check("pin config clear", 32'(pcfg), 32'h00000000);
		apb(1'b1, sas_pkg::OFF_MODE, 32'h00000081);
		wait_irq(4 * CONV);
		check("start irq", 32'(got), 32'h00000001);
		d_start = t_got - t_wr;
		check("start delay", 32'(d_start), 32'(CONV + 2));
		for (int ch = 0; ch < 8; ch++)
		begin
			v = 11'({$random(seed)} % 2047);
			if (ch == 0)
				v = 11'h000;
			if (ch == 1)
				v = 11'h001;
			if (ch == 7)
				v = 11'h7FE;
			vin[ch] <= v;
			e = code_of(v);
			apb(1'b1, sas_pkg::OFF_CHAN, 32'(ch));
			wait_irq(4 * CONV);
			check("chan irq", 32'(got), 32'h00000001);
			check("chan delay", 32'(t_got - t_wr), 32'(CONV + 2));
			rdchk("wide", sas_pkg::OFF_RES_WIDE, {16'h0000, e, 6'h00});
			rdchk("byte", sas_pkg::OFF_RES_BYTE, {24'h000000, e[9:2]});
		end
		$display("test channels done");
		wait_irq(4 * CONV);
		t1 = t_got;
		wait_irq(4 * CONV);
		check("gap irq", 32'(got), 32'h00000001);
		check("back to back gap", 32'(t_got - t1), 32'(CONV));
		$display("test continuous done");
		apb(1'b1, sas_pkg::OFF_MODE, 32'h00000001);
		vin[7] <= 11'h000;
		wait_irq(3 * CONV);
		check("stopped irq", 32'(got), 32'h00000000);
		rdchk("held wide", sas_pkg::OFF_RES_WIDE, {16'h0000, e, 6'h00});
		$display("test stop done");
		test_done();
	end
endmodule : tb_sar_adc_sequencer
